// ==== hdl/safe_escape.sv ====
`timescale 1ns/1ns
`default_nettype none
module safe_escape
  import safe_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] framing_mode_select,
  safe_byte_if.snk in,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready
);
  logic second;
  logic do_esc;

  // the start flag marks the delimiter, which is never escaped
  assign do_esc = (framing_mode_select == SAFE_MODE_ESC) && !in.start &&
                  safe_needs_esc(in.data); // [R08]
  assign out_valid = in.valid;
  always_comb begin
    out_data = in.data;
    if (do_esc) begin
      out_data = second ? (in.data ^ SAFE_ESC_XOR) : SAFE_ESC; // [R09]
    end
  end
  assign in.ready = out_ready && (!do_esc || second);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      second <= 1'b0;
    end else if (in.valid && out_ready && do_esc) begin
      second <= !second;
    end
  end
endmodule // safe_escape
`default_nettype wire

// ==== hdl/safe_frame_engine.sv ====
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// (R01) every frame opens with start byte 0x7E
// (R02) length counts frame data bytes only
// (R03) first data byte is frame type; it decides the layout
// (R04) multi-byte values go most significant byte first
// (R05) sent checksum is 0xFF minus low byte of data sum
// (R06) received checksum good when data plus checksum low byte is 0xFF
// (R07) frames with bad checksum are dropped whole
// (R08) escaped mode escapes 0x7E, 0x7D, 0x11, 0x13 after the start
// (R09) escape is 0x7D then byte XOR 0x20; receiver reverses it
// (R10) in escaped mode a raw 0x7E is always a start byte
// (R11) length and checksum ignore escape bytes
// (R12) request types below 0x80, device types 0x80 and above
// (R13) accepted requests: 0x08, 0x09, 0x10, 0x11, 0x17
// (R14) device emits 0x88 8A 8B 8D 8E 90 91 92 95 97
// (R15) responses carry request frame ID; ID 0 gets no response; code still answers 0x17 with ID 0 by 0x97
// (R16) 0x08/0x09 answered by 0x88 unless ID zero
// (R17) 0x10/0x11 answered by 0x8B status with cause unless ID zero
// (R18) receive format setting picks 0x90 or 0x91
// (R19) 0x17 always answered by 0x97
// (R20) host should discard unknown frame types
// (R21) mode 0 transparent, 1 plain framing, 2 escaped framing
// (R22) bytes before a start byte are discarded
// (R23) in escaped mode a mid-frame 0x7E restarts the frame
// (R24) reset returns parser to hunting and drops partial frame
// (R25) oversize length frames are dropped, parser hunts again
module safe_frame_engine
  import safe_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] framing_mode_select,
  input wire logic receive_format_select,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic req_valid,
  output logic [7:0] req_type,
  output logic [7:0] req_id,
  output logic [15:0] req_len,
  input wire logic [5:0] req_rd_idx,
  output logic [7:0] req_rd_data,
  input wire logic req_done,
  input wire logic send_valid,
  input wire logic [7:0] send_type,
  input wire logic [15:0] send_len,
  input wire logic send_rx_data,
  output logic send_ready,
  output logic [5:0] send_rd_idx,
  input wire logic [7:0] send_rd_data,
  output logic resp_valid,
  output logic [7:0] resp_type,
  output logic [7:0] resp_id,
  input wire logic resp_ready,
  output logic bad_frame
);
  safe_byte_if rxb();
  safe_byte_if txb();

  logic api_mode;
  assign api_mode = framing_mode_select == SAFE_MODE_PLAIN ||
                    framing_mode_select == SAFE_MODE_ESC; // [R21]

  safe_unescape u_unesc (
    .mclk(mclk),
    .rst_n(rst_n),
    .framing_mode_select(framing_mode_select),
    .in_valid(rx_valid && api_mode),
    .in_data(rx_data),
    .out(rxb.src)
  );

  // ---------------- receive parser ----------------
  logic [7:0] rbuf [SAFE_BUF_DEPTH];
  safe_rx_state_t rx_state;
  logic [15:0] rx_len;
  logic [15:0] rx_cnt;
  logic [7:0] rx_sum;
  logic rx_hold;
  logic [7:0] rx_sum_all;
  logic accepted;
  logic [7:0] first_type;
  logic [7:0] first_id;

  logic esc_mode;
  logic rx_sof;
  logic rx_byte;
  logic rx_csum_seen;
  logic [15:0] rx_len_next;
  logic len_bad;
  logic req_known;

  assign rxb.ready = 1'b1;
  assign rx_sum_all = rx_sum + rxb.data;
  assign req_rd_data = rbuf[req_rd_idx];
  assign esc_mode = framing_mode_select == SAFE_MODE_ESC;
  // plain framing has no escapes, so a 0x7E inside a frame is only data
  assign rx_sof = rxb.valid && rxb.start &&
                  (esc_mode || rx_state == SAFE_RX_HUNT); // [R10] [R22]
  assign rx_byte = rxb.valid && !rx_sof;
  assign rx_csum_seen = rx_byte && rx_state == SAFE_RX_CSUM;
  // zero length has no type byte to act on, so it is dropped as well
  assign rx_len_next = {rx_len[15:8], rxb.data}; // [R04]
  assign len_bad = rx_len_next > SAFE_MAX_LEN ||
                   rx_len_next == 16'h0000; // [R25]

  // held request blocks new frames until the user consumes it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_state <= SAFE_RX_HUNT; // [R24]
      rx_len <= 16'h0000;
      rx_cnt <= 16'h0000;
      rx_sum <= 8'h00;
    end else if (rx_sof) begin
      rx_state <= SAFE_RX_LEN_HI; // [R01] [R23]
      rx_sum <= 8'h00;
    end else if (rx_byte) begin
      unique case (rx_state)
        SAFE_RX_HUNT: rx_state <= SAFE_RX_HUNT; // [R22]
        SAFE_RX_LEN_HI: begin
          rx_len <= {rxb.data, 8'h00}; // [R04]
          rx_state <= SAFE_RX_LEN_LO;
        end
        SAFE_RX_LEN_LO: begin
          rx_len <= rx_len_next;
          rx_cnt <= 16'h0000;
          if (len_bad) begin
            rx_state <= SAFE_RX_HUNT; // [R25]
          end else begin
            rx_state <= SAFE_RX_DATA;
          end
        end
        SAFE_RX_DATA: begin
          rx_sum <= rx_sum_all; // [R11]
          rx_cnt <= rx_cnt + 16'h0001;
          if (rx_cnt + 16'h0001 == rx_len) begin
            rx_state <= SAFE_RX_CSUM; // [R02]
          end
        end
        SAFE_RX_CSUM: rx_state <= SAFE_RX_HUNT;
        default: rx_state <= SAFE_RX_HUNT;
      endcase
    end
  end

  // frames seen while a request is held are not stored; they keep the parser in step and can still raise bad_frame
  always_ff @(posedge mclk) begin
    if (rx_byte && rx_state == SAFE_RX_DATA && !rx_hold) begin
      rbuf[rx_cnt[SAFE_IDX_W-1:0]] <= rxb.data;
    end
  end

  assign accepted = rx_csum_seen && !rx_hold &&
                    rx_sum_all == SAFE_CSUM_OK; // [R06]
  assign first_type = rbuf[SAFE_IDX_TYPE[SAFE_IDX_W-1:0]];
  assign first_id = rbuf[SAFE_IDX_ID[SAFE_IDX_W-1:0]];

  // unknown request types are freed at once, without a response
  always_comb begin
    unique case (first_type)
      SAFE_T_AT_CMD, SAFE_T_AT_QUEUE, SAFE_T_TX_REQ, SAFE_T_TX_EXPL,
      SAFE_T_REMOTE: req_known = 1'b1; // [R13]
      default: req_known = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_hold <= 1'b0;
      req_valid <= 1'b0;
      req_type <= 8'h00;
      req_id <= 8'h00;
      req_len <= 16'h0000;
      bad_frame <= 1'b0;
    end else begin
      bad_frame <= rx_csum_seen && rx_sum_all != SAFE_CSUM_OK; // [R07]
      if (accepted && first_type < SAFE_RESP_MIN) begin // [R12]
        rx_hold <= 1'b1;
        req_valid <= req_known; // [R13] [R03]
        req_type <= first_type;
        req_id <= first_id;
        req_len <= rx_len;
      end else if (req_done || (rx_hold && !req_valid)) begin
        rx_hold <= 1'b0;
        req_valid <= 1'b0;
      end
    end
  end

  // ---------------- response pairing ----------------
  // answer owed once the user finishes the request
  // id zero silences 0x88 and 0x8B only; 0x97 is always owed
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_type <= 8'h00;
      resp_id <= 8'h00;
    end else if (req_valid && req_done) begin
      resp_id <= req_id; // [R15]
      unique case (req_type)
        SAFE_T_AT_CMD, SAFE_T_AT_QUEUE: begin
          resp_type <= SAFE_T_AT_RESP; // [R16]
          resp_valid <= req_id != SAFE_ZERO_ID;
        end
        SAFE_T_TX_REQ, SAFE_T_TX_EXPL: begin
          resp_type <= SAFE_T_TX_STAT; // [R17]
          resp_valid <= req_id != SAFE_ZERO_ID;
        end
        default: begin
          resp_type <= SAFE_T_REMOTE_RESP; // [R19]
          resp_valid <= 1'b1;
        end
      endcase
    end else if (resp_ready) begin
      resp_valid <= 1'b0;
    end
  end

  // ---------------- transmit framer ----------------
  safe_tx_state_t tx_state;
  logic [15:0] tx_len;
  logic [15:0] tx_cnt;
  logic [7:0] tx_sum;
  logic [7:0] tx_type;
  logic tx_go;
  logic type_ok;
  logic send_len_ok;
  logic [7:0] tx_csum;

  always_comb begin
    unique case (send_type)
      SAFE_T_AT_RESP, SAFE_T_MODEM, SAFE_T_TX_STAT, SAFE_T_ROUTE,
      SAFE_T_AGGR, SAFE_T_RX_PKT, SAFE_T_RX_EXPL, SAFE_T_IO_SAMPLE,
      SAFE_T_NODE_ID, SAFE_T_REMOTE_RESP: type_ok = 1'b1; // [R14]
      default: type_ok = 1'b0;
    endcase
  end

  assign send_ready = tx_state == SAFE_TX_IDLE && api_mode;
  assign send_len_ok = send_len != 16'h0000 && send_len <= SAFE_MAX_LEN;
  assign tx_go = send_valid && send_ready && (type_ok || send_rx_data) &&
                 send_len_ok;
  // the type byte comes from a register, the payload from the user buffer
  assign send_rd_idx = tx_cnt[SAFE_IDX_W-1:0] - 6'h01;
  assign tx_csum = SAFE_CSUM_OK - tx_sum; // [R05]

  always_comb begin
    txb.valid = tx_state != SAFE_TX_IDLE;
    txb.start = tx_state == SAFE_TX_START;
    unique case (tx_state)
      SAFE_TX_START: txb.data = SAFE_START; // [R01]
      SAFE_TX_LEN_HI: txb.data = tx_len[15:8]; // [R04]
      SAFE_TX_LEN_LO: txb.data = tx_len[7:0];
      SAFE_TX_DATA: txb.data = (tx_cnt == 16'h0000) ? tx_type : send_rd_data;
      SAFE_TX_CSUM: txb.data = tx_csum;
      default: txb.data = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_state <= SAFE_TX_IDLE;
      tx_len <= 16'h0000;
      tx_cnt <= 16'h0000;
      tx_sum <= 8'h00;
      tx_type <= 8'h00;
    end else if (tx_go) begin
      tx_state <= SAFE_TX_START;
      tx_len <= send_len; // [R02]
      tx_cnt <= 16'h0000;
      tx_sum <= 8'h00;
      tx_type <= send_rx_data ? (receive_format_select ? SAFE_T_RX_EXPL :
                 SAFE_T_RX_PKT) : send_type; // [R18]
    end else if (txb.ready && tx_state != SAFE_TX_IDLE) begin
      unique case (tx_state)
        SAFE_TX_START: tx_state <= SAFE_TX_LEN_HI;
        SAFE_TX_LEN_HI: tx_state <= SAFE_TX_LEN_LO;
        SAFE_TX_LEN_LO: tx_state <= SAFE_TX_DATA;
        SAFE_TX_DATA: begin
          tx_sum <= tx_sum + txb.data; // [R11]
          tx_cnt <= tx_cnt + 16'h0001;
          if (tx_cnt + 16'h0001 == tx_len) begin
            tx_state <= SAFE_TX_CSUM;
          end
        end
        SAFE_TX_CSUM: tx_state <= SAFE_TX_IDLE;
        default: tx_state <= SAFE_TX_IDLE;
      endcase
    end
  end

  safe_escape u_esc (
    .mclk(mclk),
    .rst_n(rst_n),
    .framing_mode_select(framing_mode_select),
    .in(txb.snk),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_ready)
  );
endmodule // safe_frame_engine
`default_nettype wire

// ==== hdl/safe_unescape.sv ====
`timescale 1ns/1ns
`default_nettype none
module safe_unescape
  import safe_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] framing_mode_select,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  safe_byte_if.src out
);
  logic esc_pend;
  logic esc_mode;

  assign esc_mode = framing_mode_select == SAFE_MODE_ESC;

  // a raw 0x7E is always a start, even right after an escape
  always_comb begin
    out.valid = 1'b0;
    out.start = 1'b0;
    out.data = in_data;
    if (in_valid) begin
      if (in_data == SAFE_START) begin
        out.valid = 1'b1; // [R10]
        out.start = 1'b1;
      end else if (esc_mode && in_data == SAFE_ESC && !esc_pend) begin
        out.valid = 1'b0;
      end else begin
        out.valid = 1'b1;
        if (esc_mode && esc_pend) begin
          out.data = in_data ^ SAFE_ESC_XOR; // [R09]
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      esc_pend <= 1'b0;
    end else if (in_valid && esc_mode) begin
      esc_pend <= (in_data == SAFE_ESC) && !esc_pend;
    end
  end
endmodule // safe_unescape
`default_nettype wire

// ==== include/safe_byte_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface safe_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic start;
  modport src(output valid, output data, output start, input ready);
  modport snk(input valid, input data, input start, output ready);
endinterface
`default_nettype wire

// ==== include/safe_pkg.sv ====
package safe_pkg;
  localparam logic [7:0] SAFE_START = 8'h7E;
  localparam logic [7:0] SAFE_ESC = 8'h7D;
  localparam logic [7:0] SAFE_XON = 8'h11;
  localparam logic [7:0] SAFE_XOFF = 8'h13;
  localparam logic [7:0] SAFE_ESC_XOR = 8'h20;
  localparam logic [7:0] SAFE_CSUM_OK = 8'hFF;
  localparam logic [7:0] SAFE_RESP_MIN = 8'h80;
  localparam logic [7:0] SAFE_T_AT_CMD = 8'h08;
  localparam logic [7:0] SAFE_T_AT_QUEUE = 8'h09;
  localparam logic [7:0] SAFE_T_TX_REQ = 8'h10;
  localparam logic [7:0] SAFE_T_TX_EXPL = 8'h11;
  localparam logic [7:0] SAFE_T_REMOTE = 8'h17;
  localparam logic [7:0] SAFE_T_AT_RESP = 8'h88;
  localparam logic [7:0] SAFE_T_MODEM = 8'h8A;
  localparam logic [7:0] SAFE_T_TX_STAT = 8'h8B;
  localparam logic [7:0] SAFE_T_ROUTE = 8'h8D;
  localparam logic [7:0] SAFE_T_AGGR = 8'h8E;
  localparam logic [7:0] SAFE_T_RX_PKT = 8'h90;
  localparam logic [7:0] SAFE_T_RX_EXPL = 8'h91;
  localparam logic [7:0] SAFE_T_IO_SAMPLE = 8'h92;
  localparam logic [7:0] SAFE_T_NODE_ID = 8'h95;
  localparam logic [7:0] SAFE_T_REMOTE_RESP = 8'h97;
  localparam logic [7:0] SAFE_ZERO_ID = 8'h00;
  localparam int SAFE_BUF_DEPTH = 64;
  localparam int SAFE_IDX_W = 6;
  localparam logic [15:0] SAFE_MAX_LEN = 16'h0040;
  localparam logic [1:0] SAFE_MODE_TRANSP = 2'h0;
  localparam logic [1:0] SAFE_MODE_PLAIN = 2'h1;
  localparam logic [1:0] SAFE_MODE_ESC = 2'h2;
  localparam logic [7:0] SAFE_IDX_TYPE = 8'h00;
  localparam logic [7:0] SAFE_IDX_ID = 8'h01;

  typedef enum logic [2:0] {
    SAFE_RX_HUNT = 3'h0,
    SAFE_RX_LEN_HI = 3'h1,
    SAFE_RX_LEN_LO = 3'h2,
    SAFE_RX_DATA = 3'h3,
    SAFE_RX_CSUM = 3'h4
  } safe_rx_state_t;

  typedef enum logic [2:0] {
    SAFE_TX_IDLE = 3'h0,
    SAFE_TX_START = 3'h1,
    SAFE_TX_LEN_HI = 3'h2,
    SAFE_TX_LEN_LO = 3'h3,
    SAFE_TX_DATA = 3'h4,
    SAFE_TX_CSUM = 3'h5
  } safe_tx_state_t;

  function automatic logic safe_needs_esc(input logic [7:0] b);
    return (b == SAFE_START) || (b == SAFE_ESC) ||
           (b == SAFE_XON) || (b == SAFE_XOFF);
  endfunction
endpackage

// ==== tb/safe_frame_engine_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module safe_frame_engine_properties
  import safe_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic send_valid,
  input wire logic send_ready,
  input wire logic [7:0] send_type,
  input wire logic [15:0] send_len,
  input wire logic send_rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic req_valid,
  input wire logic [7:0] req_type,
  input wire logic [7:0] req_id,
  input wire logic [15:0] req_len,
  input wire logic req_done,
  input wire logic resp_valid,
  input wire logic [7:0] resp_type,
  input wire logic [7:0] resp_id
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic fin;
  logic send_ok;
  assign fin = req_valid && req_done;
  assign send_ok = send_valid && send_ready && send_len != 16'h0000 &&
                   send_len <= SAFE_MAX_LEN && (send_rx_data || send_type
                   inside {8'h88, 8'h8A, 8'h8B, 8'h8D, 8'h8E, 8'h90, 8'h91,
                   8'h92, 8'h95, 8'h97});
  a_req_below_resp: assert property (
    req_valid |-> req_type < SAFE_RESP_MIN) else $error("req type high");
  a_req_known_type: assert property (
    req_valid |-> req_type inside {8'h08, 8'h09, 8'h10, 8'h11, 8'h17})
    else $error("req type unknown");
  a_req_held_stable: assert property (
    req_valid && !req_done |=> req_valid && $stable(req_type)
    && $stable(req_id)) else $error("req not held");
  a_req_len_bound: assert property (
    req_valid |-> req_len != 16'h0000 && req_len <= SAFE_MAX_LEN)
    else $error("req len out of range");
  a_cmd_resp_pair: assert property (
    fin && req_id != 8'h00 && req_type inside {8'h08, 8'h09} |=>
    resp_valid && resp_type == 8'h88 && resp_id == $past(req_id))
    else $error("cmd resp wrong");
  a_tx_status_pair: assert property (
    fin && req_id != 8'h00 && req_type inside {8'h10, 8'h11} |=>
    resp_valid && resp_type == 8'h8B && resp_id == $past(req_id))
    else $error("tx status wrong");
  a_remote_resp_always: assert property (
    fin && req_type == 8'h17 |=>
    resp_valid && resp_type == 8'h97 && resp_id == $past(req_id))
    else $error("remote resp wrong");
  a_zero_id_silent: assert property (
    fin && req_id == 8'h00 && req_type != 8'h17 && !resp_valid |=>
    !resp_valid) else $error("resp for id zero");
  a_tx_start_first: assert property (
    send_ok |=> tx_valid && tx_data == 8'h7E)
    else $error("frame not opened by start");
  a_tx_refuse_type: assert property (
    send_valid && send_ready && !send_ok |=> !tx_valid)
    else $error("refused send produced a frame");
  cover property (fin && req_id == 8'h00);
  cover property (resp_valid && resp_type == 8'h97);
  cover property (send_valid && send_ready);
endmodule // safe_frame_engine_properties
bind safe_frame_engine safe_frame_engine_properties i_props(.*);
`default_nettype wire

// ==== tb/safe_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module safe_host_model (
  input wire logic mclk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic stall
);
  logic [7:0] q_in[$];
  logic [7:0] got[$];
  logic [1:0] ph;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    ph = 2'h0;
  end
  // idle data is inverted so a stale byte never looks fresh
  always @(negedge mclk) begin
    ph <= ph + 2'h1;
    tx_ready <= !(stall && ph == 2'h0);
    if (q_in.size() != 0) begin
      rx_valid <= 1'b1;
      rx_data <= q_in.pop_front();
    end else begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end
  end
  // all bytes kept; neither this model nor the bench filters by type
  always @(posedge mclk) if (tx_valid && tx_ready) got.push_back(tx_data);
endmodule // safe_host_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  import safe_pkg::*;
  logic mclk, rst_n, receive_format_select, rx_valid, tx_valid, tx_ready;
  logic req_valid, req_done, send_valid, send_rx_data, send_ready, stall;
  logic resp_valid, resp_ready, bad_frame, bad_seen;
  logic [1:0] framing_mode_select;
  logic [7:0] rx_data, tx_data, req_type, req_id, req_rd_data, send_type;
  logic [7:0] send_rd_data, resp_type, resp_id;
  logic [15:0] req_len, send_len;
  logic [5:0] req_rd_idx, send_rd_idx;
  logic [7:0] pay[64];
  logic [7:0] enc[$];
  int fail_count, compares, cyc;
  safe_frame_engine i_dut(.*);
  safe_host_model i_host(.*);
  assign send_rd_data = pay[send_rd_idx];
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (bad_frame) bad_seen = 1'b1;
    if (cyc == 30000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic emit(input logic [7:0] b, input logic esc);
    if (esc && (b == 8'h7E || b == 8'h7D || b == 8'h11 || b == 8'h13)) begin
      enc.push_back(8'h7D);
      enc.push_back(b ^ 8'h20);
    end else enc.push_back(b);
  endtask
  task automatic encode(input logic [7:0] d[$], input logic esc,
                        input logic [7:0] flip);
    logic [7:0] s;
    logic [15:0] n;
    s = 8'h00;
    n = 16'(d.size());
    enc = {8'h7E};
    emit(n[15:8], esc);
    emit(n[7:0], esc);
    foreach (d[i]) begin
      emit(d[i], esc);
      s += d[i];
    end
    emit((8'hFF - s) ^ flip, esc);
  endtask
  task automatic rx(input logic [7:0] d[$], input logic esc,
                    input logic [7:0] flip);
    encode(d, esc, flip);
    foreach (enc[i]) i_host.q_in.push_back(enc[i]);
    for (int k = 0; k < 500 && i_host.q_in.size() != 0; k++) @(negedge mclk);
    repeat (3) @(negedge mclk);
  endtask
  task automatic fin(input logic want, input logic [7:0] t, id);
    req_done = 1'b1;
    @(negedge mclk);
    req_done = 1'b0;
    chk("resp_valid", resp_valid, want);
    if (want) chk("resp", {resp_type, resp_id}, {t, id});
    resp_ready = 1'b1;
    @(negedge mclk);
    resp_ready = 1'b0;
  endtask
  task automatic tx(input logic [7:0] t, et, input logic rxd);
    int k;
    encode('{et, pay[0], pay[1], pay[2]}, framing_mode_select[1], 8'h00);
    i_host.got.delete();
    send_type = t;
    send_len = 16'h0004;
    send_rx_data = rxd;
    send_valid = 1'b1;
    #1;
    for (k = 0; k < 50 && !send_ready; k++) begin
      @(negedge mclk);
      #1;
    end
    @(negedge mclk);
    send_valid = 1'b0;
    for (k = 0; k < 400 && i_host.got.size() < enc.size(); k++)
      @(negedge mclk);
    repeat (4) @(negedge mclk);
    chk("tx_count", i_host.got.size(), enc.size());
    foreach (enc[i]) chk("tx_byte", i_host.got[i], enc[i]);
  endtask
  task automatic s_cmd();
    i_host.q_in = {8'h55, 8'h00};
    rx('{8'h08, 8'h01, 8'h4E, 8'h48}, 0, 8'h00);
    chk("req", {req_valid, req_type, req_id}, {1'b1, 16'h0801});
    chk("req_len", req_len, 16'h0004);
    req_rd_idx = 6'h02;
    #1;
    chk("req_rd_data", req_rd_data, 8'h4E);
    fin(1, 8'h88, 8'h01);
    rx('{8'h08, 8'h05, 8'h74}, 0, 8'h00);
    chk("req", {req_valid, req_id}, {1'b1, 8'h05});
    fin(1, 8'h88, 8'h05);
  endtask
  task automatic s_types();
    logic [7:0] t[5] = '{8'h08, 8'h09, 8'h10, 8'h11, 8'h17};
    logic [7:0] r[5] = '{8'h88, 8'h88, 8'h8B, 8'h8B, 8'h97};
    for (int i = 0; i < 10; i++) begin
      rx('{t[i%5], 8'(i / 5 * 3), 8'h00}, 0, 8'h00);
      chk("req", {req_valid, req_type}, {1'b1, t[i%5]});
      fin(i >= 5 || i == 4, r[i%5], 8'(i / 5 * 3));
    end
    rx('{8'h21, 8'h01}, 0, 8'h00);
    chk("req_valid", req_valid, 0);
    rx('{8'h88, 8'h01}, 0, 8'h00);
    chk("req_valid", req_valid, 0);
  endtask
  task automatic s_bad();
    bad_seen = 1'b0;
    rx('{8'h08, 8'h02, 8'hAA}, 0, 8'h01);
    chk("bad_frame", bad_seen, 1);
    chk("req_valid", req_valid, 0);
    framing_mode_select = 2'h0;
    rx('{8'h08, 8'h02, 8'hAA}, 0, 8'h00);
    chk("req_valid", req_valid, 0);
    chk("send_ready", send_ready, 0);
  endtask
  task automatic s_esc();
    framing_mode_select = 2'h2;
    rx('{8'h08, 8'h11, 8'h7E, 8'h7D, 8'h13}, 1, 8'h00);
    chk("req", {req_valid, req_id}, {1'b1, 8'h11});
    chk("req_len", req_len, 16'h0005);
    req_rd_idx = 6'h02;
    #1;
    chk("req_rd_data", req_rd_data, 8'h7E);
    fin(1, 8'h88, 8'h11);
    i_host.q_in = {8'h7E, 8'h00, 8'h05, 8'h08};
    rx('{8'h09, 8'h04}, 1, 8'h00);
    chk("req", {req_valid, req_type, req_id}, {1'b1, 16'h0904});
    fin(1, 8'h88, 8'h04);
  endtask
  task automatic s_size();
    logic [7:0] d[$];
    framing_mode_select = 2'h1;
    d = '{8'h08, 8'h01};
    repeat (63) d.push_back(8'h20);
    rx(d, 0, 8'h00);
    chk("req_valid", req_valid, 0);
    void'(d.pop_back());
    rx(d, 0, 8'h00);
    chk("req_len", {req_valid, req_len}, {1'b1, 16'h0040});
    fin(1, 8'h88, 8'h01);
  endtask
  task automatic s_reset();
    i_host.q_in = {8'h7E, 8'h00, 8'h03, 8'h08};
    repeat (8) @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    rx('{8'h09, 8'h06, 8'h00}, 0, 8'h00);
    chk("req", {req_valid, req_id}, {1'b1, 8'h06});
    fin(1, 8'h88, 8'h06);
  endtask
  task automatic s_tx();
    stall = 1'b1;
    framing_mode_select = 2'h2;
    tx(8'h8A, 8'h8A, 0);
    framing_mode_select = 2'h1;
    receive_format_select = 1'b1;
    tx(8'h00, 8'h91, 1);
    receive_format_select = 1'b0;
    tx(8'h00, 8'h90, 1);
    i_host.got.delete();
    send_type = 8'h21;
    send_rx_data = 1'b0;
    send_valid = 1'b1;
    @(negedge mclk);
    send_valid = 1'b0;
    repeat (20) @(negedge mclk);
    chk("tx_refused", i_host.got.size(), 0);
  endtask
  initial begin
    rst_n = 1'b0;
    framing_mode_select = 2'h1;
    receive_format_select = 1'b0;
    req_rd_idx = 6'h00;
    req_done = 1'b0;
    send_valid = 1'b0;
    send_type = 8'h00;
    send_len = 16'h0000;
    send_rx_data = 1'b0;
    resp_ready = 1'b0;
    stall = 1'b0;
    bad_seen = 1'b0;
    foreach (pay[i]) pay[i] = 8'h41;
    pay[0] = 8'h7D;
    pay[1] = 8'h11;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    s_cmd();
    s_types();
    s_bad();
    s_esc();
    s_size();
    s_reset();
    s_tx();
    print_verdict();
  end
endmodule // tb
`default_nettype wire
